// ---- rtl/pdp_top.sv ----
// page and descriptor protection: APB registers, page invalidate sequencer,
// translation buffer select, descriptor type decode and vector selection
// assumes the pipeline drives request inputs synchronous to CLK
//
// Overview of operation
// RULE_01 - invalidate one 4-Kbyte page, optional write back
// RULE_02 - register write starts invalidation at once
// RULE_03 - physical address output is 32 bits
// RULE_04 - 4-Kbyte and 4-Mbyte pages coexist
// RULE_05 - size select picks 4-Mbyte buffer when enabled
// RULE_06 - types 0-7 data: accessed, writable, expand-down
// RULE_07 - types 8-F code: accessed, readable, conforming
// RULE_08 - system types: task segments, local table, reserved
// RULE_09 - gate types: call, interrupt, trap, task
// RULE_10 - fault during fault handling gives vector 8
// RULE_11 - page protection or missing page: vector 14
// RULE_12 - segment not present: vector 11
// RULE_13 - stack limit or missing stack: vector 12
// RULE_14 - invalid task segment switch: vector 10
// RULE_15 - general protection: vector 13
// RULE_16 - misaligned gives 17 only with both flags
// RULE_17 - other causes on fixed vectors, 9 unused
// RULE_18 - software interrupt may raise any vector
// RULE_19 - hold four descriptor table pointers
// RULE_20 - one vector per cycle with valid strobe
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
module pdp_top (
	input  wire logic        CLK,
	input  wire logic        RST_N,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// cache and buffer maintenance
	output logic             CACHE_REQ,
	output logic             CACHE_WB,
	output logic      [31:0] CACHE_LINE_ADDR,
	input  wire logic        CACHE_ACK,
	output logic             TLB_INVAL,
	output logic             INVAL_BUSY,
	// translation
	input  wire logic        XL_VALID,
	input  wire logic [31:0] XL_LIN_ADDR,
	input  wire logic [31:0] XL_DIR_ENTRY,
	input  wire logic [31:0] XL_TBL_ENTRY,
	output logic             XL_DONE,
	output logic             XL_USE_LARGE,
	output logic      [31:0] XL_PHYS_ADDR,
	// descriptor type decode
	input  wire logic        DESC_VALID,
	input  wire logic        DESC_SYS,
	input  wire logic [3:0]  DESC_TYPE,
	output logic             DESC_DATA,
	output logic             DESC_CODE,
	output logic             DESC_ACCESSED,
	output logic             DESC_WRITABLE,
	output logic             DESC_READABLE,
	output logic             DESC_EXP_DOWN,
	output logic             DESC_CONFORMING,
	output logic             DESC_TASK_SEG,
	output logic             DESC_TASK_SEG_BUSY,
	output logic             DESC_WIDE,
	output logic             DESC_LOCAL_TABLE,
	output logic             DESC_CALL_GATE,
	output logic             DESC_INT_GATE,
	output logic             DESC_TRAP_GATE,
	output logic             DESC_TASK_GATE,
	output logic             DESC_RESERVED,
	// exceptions
	input  wire logic [14:0] FAULT_CAUSE,
	input  wire logic        FAULT_ACTIVE,
	input  wire logic        ALIGN_CHECK_FLAG,
	input  wire logic        SW_INT,
	input  wire logic [7:0]  SW_VEC,
	output logic             EXC_VALID,
	output logic      [7:0]  EXC_VECTOR
);
	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	logic        ctrl_lpe;   // large_page_enable
	logic        ctrl_align; // align_mask_bit
	logic [7:0]  last_vec;   // last reported vector, for software
	logic [31:0] ptr_rdata;  // table pointer read data

	wire access  = PSEL & PENABLE;
	wire commit  = access & PREADY;           // edge where the master samples
	wire hit_pir = PADDR == pdp_pkg::PDP_OFF_PIR;
	wire hit_ctl = PADDR == pdp_pkg::PDP_OFF_CTRL;
	wire hit_sta = PADDR == pdp_pkg::PDP_OFF_STAT;
	wire hit_tbl = (PADDR & pdp_pkg::PDP_TBL_MASK) == pdp_pkg::PDP_OFF_TBL;
	wire hit_any = hit_pir | hit_ctl | hit_sta | hit_tbl;
	wire wr_pir  = commit & PWRITE & hit_pir;
	wire wr_ctl  = commit & PWRITE & hit_ctl;
	wire wr_tbl  = commit & PWRITE & hit_tbl;
	wire [1:0] tbl_idx = PADDR[pdp_pkg::PDP_TBL_IDX_LSB +: 2];

	// read mux; the page register reads back its latched page
	logic [31:0] page_base;
	logic        page_wb;
	wire  [31:0] rd_mux =
		hit_pir ? (page_base | {31'h0, page_wb}) :
		hit_ctl ? {30'h0, ctrl_align, ctrl_lpe} :
		hit_sta ? {16'h0, last_vec, 7'h0, INVAL_BUSY} :
		hit_tbl ? ptr_rdata : 32'h0000_0000;

	// one wait state: the pointer store answers from a register
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h0000_0000;
		end else begin
			PREADY  <= access & !PREADY;
			PSLVERR <= access & !PREADY & !hit_any; // unmapped answers an error
			PRDATA  <= (access & !PREADY & !PWRITE) ? rd_mux : 32'h0000_0000;
		end
	end

	// control bits steer translation and alignment gating
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			{ctrl_align, ctrl_lpe} <= pdp_pkg::PDP_CTRL_RST;
		end else if (wr_ctl) begin
			ctrl_lpe   <= PWDATA[pdp_pkg::PDP_CTRL_LPE_BIT];
			ctrl_align <= PWDATA[pdp_pkg::PDP_CTRL_ALIGN_BIT];
		end
	end

	// four table pointers live in the small store
	pdp_ptr_mem u_ptr ( // RULE_19
		.clk     (CLK),
		.rst_n   (RST_N),
		.wr_en   (wr_tbl),
		.wr_idx  (tbl_idx),
		.wr_data (PWDATA),
		.rd_idx  (tbl_idx),
		.rd_data (ptr_rdata)
	);

	// ------------------------------------------------------------
	// page invalidate sequencer
	// ------------------------------------------------------------
	pdp_pkg::pdp_state_t state;
	pdp_pkg::pdp_state_t next_state;
	logic [pdp_pkg::PDP_LINE_W-1:0] line;

	wire last_line = line == pdp_pkg::PDP_LAST_LINE;
	wire line_ack  = (state == pdp_pkg::PDP_ST_REQ) & CACHE_ACK;
	// a write while busy is dropped; the running page finishes first
	wire start     = wr_pir & (state == pdp_pkg::PDP_ST_IDLE);

	// state selection
	always_comb begin
		next_state = state;
		case (state)
			pdp_pkg::PDP_ST_IDLE: begin
				if (start) begin
					next_state = pdp_pkg::PDP_ST_REQ; // RULE_02
				end
			end
			pdp_pkg::PDP_ST_REQ: begin
				if (line_ack & last_line) begin
					next_state = pdp_pkg::PDP_ST_DONE;
				end
			end
			pdp_pkg::PDP_ST_DONE: begin
				next_state = pdp_pkg::PDP_ST_IDLE;
			end
			default: begin
				next_state = pdp_pkg::PDP_ST_IDLE; // recover from bad code
			end
		endcase
	end

	// state, page latch and line walk
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state     <= pdp_pkg::PDP_ST_IDLE;
			page_base <= 32'h0000_0000;
			page_wb   <= 1'b0;
			line      <= '0;
		end else begin
			state <= next_state;
			if (start) begin
				// only the page number counts: one 4-Kbyte page
				page_base <= {PWDATA[31:pdp_pkg::PDP_PAGE_LSB], 12'h000}; // RULE_01
				page_wb   <= PWDATA[pdp_pkg::PDP_PIR_FLUSH_BIT];
				line      <= '0;
			end else if (line_ack) begin
				line <= line + 7'h01;
			end
		end
	end

	// cache side outputs, all registered
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			CACHE_REQ       <= 1'b0;
			CACHE_WB        <= 1'b0;
			CACHE_LINE_ADDR <= 32'h0000_0000;
			TLB_INVAL       <= 1'b0;
			INVAL_BUSY      <= 1'b0;
		end else begin
			CACHE_REQ  <= next_state == pdp_pkg::PDP_ST_REQ;
			INVAL_BUSY <= next_state != pdp_pkg::PDP_ST_IDLE;
			TLB_INVAL  <= start; // drop the page translation with the lines
			if (start) begin
				CACHE_LINE_ADDR <= {PWDATA[31:pdp_pkg::PDP_PAGE_LSB], 12'h000};
				CACHE_WB        <= PWDATA[pdp_pkg::PDP_PIR_FLUSH_BIT]; // RULE_01
			end else if (line_ack & !last_line) begin
				CACHE_LINE_ADDR <= page_base | {20'h0, line + 7'h01, 5'h00}; // RULE_01
			end
		end
	end

	// ------------------------------------------------------------
	// translation buffer select and physical address
	// ------------------------------------------------------------
	// size select is bit 7 of the directory entry
	wire use_large = ctrl_lpe & XL_DIR_ENTRY[pdp_pkg::PDP_DIR_SIZE_BIT]; // RULE_05
	wire [31:0] phys_large = {XL_DIR_ENTRY[31:pdp_pkg::PDP_LARGE_LSB],
		XL_LIN_ADDR[pdp_pkg::PDP_LARGE_LSB-1:0]};
	wire [31:0] phys_small = {XL_TBL_ENTRY[31:pdp_pkg::PDP_PAGE_LSB],
		XL_LIN_ADDR[pdp_pkg::PDP_PAGE_LSB-1:0]};

	// chosen per access, so both sizes share one directory
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			XL_DONE      <= 1'b0;
			XL_USE_LARGE <= 1'b0;
			XL_PHYS_ADDR <= 32'h0000_0000;
		end else begin
			XL_DONE <= XL_VALID;
			if (XL_VALID) begin
				XL_USE_LARGE <= use_large; // RULE_04
				XL_PHYS_ADDR <= use_large ? phys_large : phys_small; // RULE_03
			end
		end
	end

	// ------------------------------------------------------------
	// descriptor type decode
	// ------------------------------------------------------------
	wire app   = DESC_VALID & !DESC_SYS;
	wire sys   = DESC_VALID & DESC_SYS;
	wire [3:0] t = DESC_TYPE;
	wire task_seg = sys & (t == 4'h1 | t == 4'h3 | t == 4'h9 | t == 4'hB);
	// reserved codes carry no width, so they must not raise the wide flag
	wire rsvd     = sys & (t == 4'h0 | t == 4'h8 | t == 4'hA | t == 4'hD);

	// registered flags, valid the cycle after DESC_VALID
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			{DESC_DATA, DESC_CODE, DESC_ACCESSED, DESC_WRITABLE} <= 4'h0;
			{DESC_READABLE, DESC_EXP_DOWN, DESC_CONFORMING} <= 3'h0;
			{DESC_TASK_SEG, DESC_TASK_SEG_BUSY, DESC_WIDE, DESC_LOCAL_TABLE} <= 4'h0;
			{DESC_CALL_GATE, DESC_INT_GATE, DESC_TRAP_GATE} <= 3'h0;
			{DESC_TASK_GATE, DESC_RESERVED} <= 2'h0;
		end else begin
			DESC_DATA       <= app & !t[3]; // RULE_06
			DESC_CODE       <= app & t[3]; // RULE_07
			DESC_ACCESSED   <= app & t[0];
			DESC_WRITABLE   <= app & !t[3] & t[1]; // RULE_06
			DESC_EXP_DOWN   <= app & !t[3] & t[2];
			DESC_READABLE   <= app & t[3] & t[1]; // RULE_07
			DESC_CONFORMING <= app & t[3] & t[2];
			DESC_TASK_SEG      <= task_seg; // RULE_08
			DESC_TASK_SEG_BUSY <= task_seg & t[1];
			DESC_LOCAL_TABLE   <= sys & (t == 4'h2);
			DESC_WIDE          <= sys & t[3] & !rsvd; // 32-bit segment or gate
			DESC_CALL_GATE  <= sys & (t[2:0] == 3'h4); // RULE_09
			DESC_TASK_GATE  <= sys & (t == 4'h5);
			DESC_INT_GATE   <= sys & (t[2:0] == 3'h6) & (t != 4'hE | t[3]);
			DESC_TRAP_GATE  <= sys & (t[2:0] == 3'h7);
			DESC_RESERVED   <= rsvd; // RULE_08
		end
	end

	// ------------------------------------------------------------
	// vector selection
	// ------------------------------------------------------------
	// alignment cause only counts with both flags set
	logic [14:0] cause;
	always_comb begin
		cause = FAULT_CAUSE;
		cause[pdp_pkg::PDP_CAUSE_ALIGN] = FAULT_CAUSE[pdp_pkg::PDP_CAUSE_ALIGN]
			& ALIGN_CHECK_FLAG & ctrl_align; // RULE_16
	end

	// first raised slot wins; vectors are or-ed along the chain
	logic [pdp_pkg::PDP_NCAUSE:0] seen;
	logic [7:0] vchain [pdp_pkg::PDP_NCAUSE+1];
	assign seen[0]   = 1'b0;
	assign vchain[0] = 8'h00;
	for (genvar i = 0; i < pdp_pkg::PDP_NCAUSE; i++) begin : g_cause
		wire win = cause[i] & !seen[i];
		assign seen[i+1]   = seen[i] | cause[i];
		assign vchain[i+1] = vchain[i] | (win ? pdp_pkg::pdp_cause_vec(i) : 8'h00); // RULE_17
	end

	wire any_fault = seen[pdp_pkg::PDP_NCAUSE];
	wire [7:0] next_vec = (any_fault & FAULT_ACTIVE) ? pdp_pkg::PDP_VEC_DOUBLE : // RULE_10
		any_fault ? vchain[pdp_pkg::PDP_NCAUSE] : SW_VEC; // RULE_18

	// one vector per cycle; a software interrupt yields to faults
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			EXC_VALID  <= 1'b0;
			EXC_VECTOR <= 8'h00;
			last_vec   <= 8'h00;
		end else begin
			EXC_VALID <= any_fault | SW_INT; // RULE_20
			if (any_fault | SW_INT) begin
				EXC_VECTOR <= next_vec;
				last_vec   <= next_vec;
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	AST_PAGE_ONE_PAGE: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_01
		CACHE_REQ |-> CACHE_LINE_ADDR[31:12] == page_base[31:12])
		else $error("line address left the page");

	AST_START_NOW: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_02
		start |=> CACHE_REQ && TLB_INVAL && INVAL_BUSY)
		else $error("invalidation did not start");

	AST_PHYS_SMALL: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_03
		XL_VALID && !use_large |=> XL_PHYS_ADDR[11:0] == $past(XL_LIN_ADDR[11:0]))
		else $error("small page offset wrong");

	AST_LARGE_SEL: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_05
		XL_VALID |=> XL_USE_LARGE == ($past(ctrl_lpe) && $past(XL_DIR_ENTRY[7])))
		else $error("buffer select wrong");

	AST_DATA_CODE: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_06
		DESC_VALID && !DESC_SYS |=> DESC_DATA == !$past(DESC_TYPE[3]) && DESC_CODE != DESC_DATA)
		else $error("application class wrong");

	AST_DOUBLE: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_10
		any_fault && FAULT_ACTIVE |=> EXC_VALID && EXC_VECTOR == 8'h08)
		else $error("double fault not reported");

	AST_PAGE_VEC: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_11
		FAULT_CAUSE == 15'h1000 && !FAULT_ACTIVE |=> EXC_VECTOR == 8'h0E)
		else $error("page fault vector wrong");

	AST_ALIGN_GATE: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_16
		FAULT_CAUSE == 15'h4000 && !(ALIGN_CHECK_FLAG && ctrl_align) && !SW_INT |=> !EXC_VALID)
		else $error("alignment reported while masked");

	AST_NO_NINE: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_17
		EXC_VALID && !$past(SW_INT) |-> EXC_VECTOR != 8'h09)
		else $error("reserved vector raised");

	AST_SW_VEC: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_18
		SW_INT && FAULT_CAUSE == 15'h0000 |=> EXC_VALID && EXC_VECTOR == $past(SW_VEC))
		else $error("software vector lost");

	AST_STROBE: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_20
		EXC_VALID |-> $past(any_fault || SW_INT))
		else $error("strobe without cause");

	AST_SEQ_LEN: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_01
		line_ack && last_line |=> state == pdp_pkg::PDP_ST_DONE ##1 !INVAL_BUSY)
		else $error("walk did not end after last line");
endmodule

// ---- rtl/pdp_pkg.sv ----
// page and descriptor protection: shared constants, register map, vectors
// assumes a 32-bit APB register bus and one processor clock
package pdp_pkg;

	// ------------------------------------------------------------
	// register map (byte offsets on APB)
	// ------------------------------------------------------------
	localparam logic [7:0] PDP_OFF_PIR    = 8'h00; // page_invalidate_register
	localparam logic [7:0] PDP_OFF_CTRL   = 8'h04; // feature and alignment controls
	localparam logic [7:0] PDP_OFF_STAT   = 8'h08; // busy and last vector
	localparam logic [7:0] PDP_OFF_TBL    = 8'h10; // four table pointers, 10h..1Ch
	localparam logic [7:0] PDP_TBL_MASK   = 8'hF0; // decode of the pointer window
	localparam int         PDP_TBL_IDX_LSB = 2;    // word index inside the window

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int          PDP_PIR_FLUSH_BIT = 0;  // write modified lines back first
	localparam int          PDP_CTRL_LPE_BIT  = 0;  // large_page_enable
	localparam int          PDP_CTRL_ALIGN_BIT = 1; // align_mask_bit
	localparam int          PDP_DIR_SIZE_BIT  = 7;  // page_size_select in directory_entry
	localparam logic [1:0]  PDP_CTRL_RST      = 2'h0;
	localparam int          PDP_STAT_VEC_LSB  = 8;  // last vector field
	localparam int          PDP_PAGE_LSB      = 12; // 4-Kbyte page offset width
	localparam int          PDP_LARGE_LSB     = 22; // 4-Mbyte page offset width
	localparam int          PDP_LINE_LSB      = 5;  // 32-byte cache line
	localparam int          PDP_LINE_W        = 7;  // 128 lines per 4-Kbyte page
	localparam logic [6:0]  PDP_LAST_LINE     = 7'h7F;

	// ------------------------------------------------------------
	// exception vectors and cause slots (slot order is priority)
	// ------------------------------------------------------------
	localparam int         PDP_NCAUSE     = 15;
	localparam int         PDP_CAUSE_ALIGN = 14; // alignment slot, gated by flags
	localparam logic [7:0] PDP_VEC_DOUBLE = 8'h08;
	localparam logic [7:0] PDP_VEC_PAGE   = 8'h0E;

	// vector number for each cause slot
	function automatic logic [7:0] pdp_cause_vec(input int slot);
		case (slot)
			0:       return 8'h00; // divide error
			1:       return 8'h01; // debug
			2:       return 8'h02; // unmaskable interrupt
			3:       return 8'h03; // breakpoint
			4:       return 8'h04; // overflow
			5:       return 8'h05; // bounds
			6:       return 8'h06; // invalid opcode
			7:       return 8'h07; // device not available
			8:       return 8'h0A; // RULE_14
			9:       return 8'h0B; // RULE_12
			10:      return 8'h0C; // RULE_13
			11:      return 8'h0D; // RULE_15
			12:      return 8'h0E; // RULE_11
			13:      return 8'h10; // floating-point error
			default: return 8'h11; // alignment check
		endcase
	endfunction

	// ------------------------------------------------------------
	// page invalidate sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		PDP_ST_IDLE = 3'h1,
		PDP_ST_REQ  = 3'h2,
		PDP_ST_DONE = 3'h4
	} pdp_state_t;

endpackage

// ---- rtl/pdp_ptr_mem.sv ----
// page and descriptor protection: table pointer storage
// assumes one write port and a registered read port on the same clock
`timescale 1ns/1ps
module pdp_ptr_mem (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        wr_en,
	input  wire logic [1:0]  wr_idx,
	input  wire logic [31:0] wr_data,
	input  wire logic [1:0]  rd_idx,
	output logic      [31:0] rd_data
);
	// four words: global, interrupt, local table, task segment pointer
	logic [31:0] mem [4];

	// ------------------------------------------------------------
	// storage, cleared at reset so reads are defined
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem <= '{default: 32'h0000_0000};
		end else if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	// read data leaves through a register, one cycle after the index
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 32'h0000_0000;
		end else begin
			rd_data <= mem[rd_idx];
		end
	end
endmodule

// ---- tb/pdp_cache_model.sv ----
// cache side model: answers line requests of the invalidate sequencer
// assumes a request is a level held until its acknowledge is seen
`timescale 1ns/1ps
module pdp_cache_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       req,
	input  wire logic [3:0] delay,
	output logic            ack
);
	logic [3:0] cnt; // cycles waited on the current line

	// ----------------------------------------
	// acknowledge after delay cycles; 0 acks every cycle, the fastest a cache can
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 4'h0;
			ack <= 1'b0;
		end else if (!req) begin
			cnt <= 4'h0;
			ack <= 1'b0;
		end else if (cnt >= delay) begin
			cnt <= 4'h0;
			ack <= 1'b1;
		end else begin
			cnt <= cnt + 4'h1;
			ack <= 1'b0;
		end
	end
endmodule

// ---- tb/tb_page_and_descriptor_protection.sv ----
// testbench: APB master tasks and pulse drivers around the protection block
// assumes no fixed wait state: a bus wait ends on pready or on the watchdog
`timescale 1ns/1ps
module tb_page_and_descriptor_protection;
	logic        CLK = 1'b0, RST_N = 1'b0;
	logic        PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er;
	logic [7:0]  PADDR, SW_VEC, EXC_VECTOR;
	logic [31:0] PWDATA, PRDATA, rd, exp_addr, CACHE_LINE_ADDR;
	logic        CACHE_REQ, CACHE_WB, CACHE_ACK, TLB_INVAL, INVAL_BUSY, cur_fl;
	logic        XL_VALID, XL_DONE, XL_USE_LARGE, DESC_VALID, DESC_SYS;
	logic [31:0] XL_LIN_ADDR, XL_DIR_ENTRY, XL_TBL_ENTRY, XL_PHYS_ADDR;
	logic [3:0]  DESC_TYPE, ack_delay;
	logic [15:0] dflags; // descriptor flags, data first, reserved last
	logic [14:0] FAULT_CAUSE;
	logic        FAULT_ACTIVE, ALIGN_CHECK_FLAG, SW_INT, EXC_VALID;
	int          bad_count, tests_run, lines;
	localparam logic [7:0] VEC [15] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
		8'h07, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h10, 8'h11};

	always #2 CLK = ~CLK;

	pdp_top dut_u (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.CACHE_REQ(CACHE_REQ), .CACHE_WB(CACHE_WB), .CACHE_LINE_ADDR(CACHE_LINE_ADDR),
		.CACHE_ACK(CACHE_ACK), .TLB_INVAL(TLB_INVAL), .INVAL_BUSY(INVAL_BUSY),
		.XL_VALID(XL_VALID), .XL_LIN_ADDR(XL_LIN_ADDR), .XL_DIR_ENTRY(XL_DIR_ENTRY),
		.XL_TBL_ENTRY(XL_TBL_ENTRY), .XL_DONE(XL_DONE), .XL_USE_LARGE(XL_USE_LARGE),
		.XL_PHYS_ADDR(XL_PHYS_ADDR), .DESC_VALID(DESC_VALID), .DESC_SYS(DESC_SYS),
		.DESC_TYPE(DESC_TYPE), .DESC_DATA(dflags[15]), .DESC_CODE(dflags[14]),
		.DESC_ACCESSED(dflags[13]), .DESC_WRITABLE(dflags[12]), .DESC_READABLE(dflags[11]),
		.DESC_EXP_DOWN(dflags[10]), .DESC_CONFORMING(dflags[9]), .DESC_TASK_SEG(dflags[8]),
		.DESC_TASK_SEG_BUSY(dflags[7]), .DESC_WIDE(dflags[6]), .DESC_LOCAL_TABLE(dflags[5]),
		.DESC_CALL_GATE(dflags[4]), .DESC_INT_GATE(dflags[3]), .DESC_TRAP_GATE(dflags[2]),
		.DESC_TASK_GATE(dflags[1]), .DESC_RESERVED(dflags[0]), .FAULT_CAUSE(FAULT_CAUSE),
		.FAULT_ACTIVE(FAULT_ACTIVE), .ALIGN_CHECK_FLAG(ALIGN_CHECK_FLAG), .SW_INT(SW_INT),
		.SW_VEC(SW_VEC), .EXC_VALID(EXC_VALID), .EXC_VECTOR(EXC_VECTOR));

	pdp_cache_model cache_u (.clk(CLK), .rst_n(RST_N), .req(CACHE_REQ), .delay(ack_delay),
		.ack(CACHE_ACK));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t ns: %s", $time, msg);
		end
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// one APB transfer; request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do begin
			@(posedge CLK);
		end while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	// the caller raised its pulse at an edge; drop it one edge later and settle
	task automatic fire();
		@(posedge CLK);
		XL_VALID <= 1'b0;
		DESC_VALID <= 1'b0;
		FAULT_CAUSE <= 15'h0000;
		SW_INT <= 1'b0;
		@(negedge CLK);
	endtask

	task automatic exc(input logic [14:0] c, input logic act, input logic fl, input logic sw,
		input logic [7:0] sv, input logic [7:0] ev, input logic vld);
		@(posedge CLK);
		FAULT_CAUSE <= c;
		FAULT_ACTIVE <= act;
		ALIGN_CHECK_FLAG <= fl;
		SW_INT <= sw;
		SW_VEC <= sv;
		fire();
		chk({23'h0, EXC_VALID, vld ? EXC_VECTOR : 8'h00}, {23'h0, vld, ev}, "vector");
		@(negedge CLK);
		chk({31'h0, EXC_VALID}, 32'h0, "vector strobe length");
	endtask

	// expected descriptor flags in the order of dflags
	function automatic logic [15:0] dexp(input logic s, input logic [3:0] t);
		logic [15:0] f = 16'h0000;
		if (!s) begin
			f[15:13] = {!t[3], t[3], t[0]};
			f[12:9] = {!t[3] & t[1], t[3] & t[1], !t[3] & t[2], t[3] & t[2]};
		end else begin
			f[8:5] = {t inside {1, 3, 9, 11}, t inside {3, 11}, t inside {9, 11, 12, 14, 15}, t == 2};
			f[4:0] = {t inside {4, 12}, t inside {6, 14}, t inside {7, 15}, t == 5,
				t inside {0, 8, 10, 13}};
		end
		return f;
	endfunction

	// one page invalidate; lines are counted and checked by the monitor
	task automatic inval(input logic [31:0] pg, input logic fl, input logic [3:0] dl);
		int n = 0;
		ack_delay <= dl;
		exp_addr = pg;
		cur_fl = fl;
		lines = 0;
		apb(1'b1, 8'h00, pg | {31'h0, fl});
		@(negedge CLK);
		chk({28'h0, TLB_INVAL, INVAL_BUSY, CACHE_REQ, CACHE_WB}, {28'h0, 3'h7, fl}, "start");
		chk(CACHE_LINE_ADDR, pg, "first line");
		@(negedge CLK);
		chk({31'h0, TLB_INVAL}, 32'h0, "buffer pulse");
		apb(1'b1, 8'h00, 32'h0000_5000);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, pg | {31'h0, fl}, "busy write kept out");
		while (INVAL_BUSY === 1'b1 && n < 3000) begin
			@(negedge CLK);
			n++;
		end
		chk(lines, 128, "line count");
		chk({31'h0, CACHE_REQ}, 32'h0, "request released");
	endtask

	// monitor of every acknowledged line: ascending, inside the page, flush kept
	always @(posedge CLK) begin
		if (CACHE_REQ === 1'b1 && CACHE_ACK === 1'b1) begin
			chk(CACHE_LINE_ADDR, exp_addr, "line address");
			chk({31'h0, CACHE_WB}, {31'h0, cur_fl}, "flush option");
			exp_addr = exp_addr + 32'h20;
			lines++;
		end
	end

	// watchdog well beyond the longest expected run
	initial begin
		repeat (20000) @(posedge CLK);
		bad_count++;
		test_done();
	end

	initial begin
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA, XL_VALID, XL_LIN_ADDR, XL_DIR_ENTRY} = '0;
		{XL_TBL_ENTRY, DESC_VALID, DESC_SYS, DESC_TYPE, FAULT_CAUSE, FAULT_ACTIVE} = '0;
		{ALIGN_CHECK_FLAG, SW_INT, SW_VEC, ack_delay, cur_fl, exp_addr} = '0;
		repeat (5) @(posedge CLK);
		RST_N <= 1'b1;
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h0, "control reset");
		for (int i = 0; i < 4; i++) apb(1'b1, 8'h10 + 8'(4 * i), 32'hA5C3_0F10 + i);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 8'h10 + 8'(4 * i), 32'h0);
			chk(rd, 32'hA5C3_0F10 + i, "table pointer");
		end
		apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
		chk({31'h0, er}, 32'h1, "unmapped write");
		apb(1'b0, 8'h80, 32'h0);
		chk({er, rd[30:0]}, 32'h8000_0000, "unmapped read");
		$display("test registers done");
		inval(32'hFEDC_B000, 1'b1, 4'h3);
		inval(32'h0001_2000, 1'b0, 4'h0);
		$display("test invalidate done");
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, 8'h04, {30'h0, 1'b1, k[1]});
			@(posedge CLK);
			XL_VALID <= 1'b1;
			XL_LIN_ADDR <= 32'h1234_5678;
			XL_DIR_ENTRY <= 32'hAAC0_0000 | {24'h0, k[0], 7'h0};
			XL_TBL_ENTRY <= 32'h9876_5ABC;
			fire();
			chk({30'h0, XL_DONE, XL_USE_LARGE}, {30'h0, 1'b1, k[1] & k[0]}, "size");
			chk(XL_PHYS_ADDR, (k == 3) ? 32'hAAF4_5678 : 32'h9876_5678, "phys");
		end
		$display("test translation done");
		for (int i = 0; i < 32; i++) begin
			@(posedge CLK);
			DESC_VALID <= 1'b1;
			DESC_SYS <= i[4];
			DESC_TYPE <= i[3:0];
			fire();
			chk({16'h0, dflags}, {16'h0, dexp(i[4], i[3:0])}, "type decode");
		end
		$display("test descriptors done");
		for (int i = 0; i < 15; i++) exc(15'h1 << i, 1'b0, 1'b1, 1'b0, 8'h00, VEC[i], 1'b1);
		exc(15'h4000, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
		exc(15'h1008, 1'b0, 1'b0, 1'b0, 8'h00, 8'h03, 1'b1);
		exc(15'h1000, 1'b1, 1'b0, 1'b0, 8'h00, 8'h08, 1'b1);
		exc(15'h0800, 1'b0, 1'b0, 1'b1, 8'hFF, 8'h0D, 1'b1);
		for (int v = 0; v < 256; v += 85) exc(15'h0, 1'b0, 1'b0, 1'b1, 8'(v), 8'(v), 1'b1);
		apb(1'b1, 8'h04, 32'h0);
		exc(15'h4000, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00, 1'b0);
		apb(1'b0, 8'h08, 32'h0);
		chk({24'h0, rd[15:8]}, 32'h0000_00FF, "last vector");
		$display("test exceptions done");
		test_done();
	end
endmodule
